// >>> design/pmt_pkg.sv
// Package for the privilege mode tracker
package pmt_pkg;
    // Control register field positions
    localparam int CTRL_W        = 2;
    localparam int CTRL_USER_BIT = 0;
    localparam int CTRL_ALT_BIT  = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    // Execution status compressed-state bit
    localparam int ESR_W       = 32;
    localparam int ESR_CMP_BIT = 24;
    localparam logic [ESR_W-1:0] ESR_RST = 32'h0100_0000;
    localparam int NEST_W_DEF  = 8;

    typedef enum logic [1:0] {
        PMT_PRIV_THREAD = 2'b00,
        PMT_PRIV_HANDLER = 2'b01,
        PMT_USER_THREAD = 2'b10
    } pmt_state_t;

    // Access attempts from the instruction decoder
    typedef struct packed {
        logic restr_instr;
        logic special_reg;
        logic config_reg;
        logic debug_comp;
        logic legacy_isa;
    } pmt_access_t;

    // Exception events
    typedef struct packed {
        logic entry;
        logic ret;
    } pmt_exc_t;
endpackage

// >>> design/pmt_tracker.sv
// Privilege level, mode and stack selection tracker
//
// Overview of operation
// (RULE1) Handler mode exists only at privileged level
// (RULE2) Handler while servicing exception, thread otherwise
// (RULE3) User-level blocked accesses raise a fault
// (RULE4) Privileged level never raises privilege fault
// (RULE5) Two stack pointers, banked active selection
// (RULE6) Only compressed encoding; legacy state faults
// (RULE7) Reset while external reset pin low
// (RULE8) Process stack for user thread, and for privileged thread when control bit 1 set
// (RULE9) Control bit 0 selects thread privilege
// (RULE10) Control bit 1 selects alternate stack
// (RULE11) Compressed status bit reads one; clearing faults
// (RULE12) Outermost return restores thread from control
`timescale 1ns/100ps
`default_nettype none
module pmt_tracker
    import pmt_pkg::*;
#(
    parameter int NEST_W = NEST_W_DEF
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              ext_reset_n,
    // Decoder access attempts
    input  wire pmt_access_t       access,
    // Exception entry and return
    input  wire pmt_exc_t          exc,
    // Control register write
    input  wire logic              ctrl_we,
    input  wire logic [CTRL_W-1:0] ctrl_wdata,
    // Status register write
    input  wire logic              esr_we,
    input  wire logic [ESR_W-1:0]  esr_wdata,
    // State outputs
    output logic                   priv_user,
    output logic                   handler_mode,
    output logic                   sel_process_sp,
    output logic [CTRL_W-1:0]      ctrl_rdata,
    output logic [ESR_W-1:0]       exec_status_reg,
    output logic                   fault
);
    // Nesting counter needs at least two bits for the outermost compare
    if (NEST_W < 2 || NEST_W > 16)
    begin : g_bad_nest
        $error("NEST_W out of range");
    end

    pmt_state_t        state_r, state_nxt;
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [NEST_W-1:0] nest_r, nest_nxt;
    logic              fault_r, fault_nxt;
    logic [ESR_W-1:0]  esr_r, esr_nxt;
    logic              blocked;

    // Pull-up on the pin is a pad attribute; low here means reset
    always_comb
    begin
        blocked   = access.restr_instr | access.special_reg
                  | access.config_reg | access.debug_comp;
        ctrl_nxt  = ctrl_r;
        nest_nxt  = nest_r;
        esr_nxt   = esr_r;
        fault_nxt = 1'b0;
        state_nxt = state_r;
        if (ctrl_we && state_r != PMT_USER_THREAD)
        begin
            ctrl_nxt[CTRL_USER_BIT] = ctrl_wdata[CTRL_USER_BIT];            // RULE9
            ctrl_nxt[CTRL_ALT_BIT]  = ctrl_wdata[CTRL_ALT_BIT]
                                    & (state_r != PMT_PRIV_HANDLER);        // RULE10
        end
        if (esr_we)
        begin
            esr_nxt = esr_wdata;
            esr_nxt[ESR_CMP_BIT] = 1'b1;                                    // RULE11
            if (!esr_wdata[ESR_CMP_BIT])
                fault_nxt = 1'b1;                                           // RULE11
        end
        if (state_r == PMT_USER_THREAD && (blocked || ctrl_we))
            fault_nxt = 1'b1;                                               // RULE3
        if (access.legacy_isa)
            fault_nxt = 1'b1;                                               // RULE6
        if (exc.entry || fault_nxt)
        begin
            state_nxt = PMT_PRIV_HANDLER;                                   // RULE2
            if (nest_r != {NEST_W{1'b1}})
                nest_nxt = nest_r + 1'b1;
        end
        else if (exc.ret && state_r == PMT_PRIV_HANDLER)
        begin
            nest_nxt = nest_r - 1'b1;
            if (nest_r == {{(NEST_W-1){1'b0}}, 1'b1})
                state_nxt = ctrl_r[CTRL_USER_BIT] ? PMT_USER_THREAD
                                                  : PMT_PRIV_THREAD;        // RULE12
        end
        else if (state_r == PMT_PRIV_THREAD && ctrl_nxt[CTRL_USER_BIT])
            state_nxt = PMT_USER_THREAD;                                    // RULE9
    end

    always_ff @(posedge clk_sys or negedge ext_reset_n)
    begin
        if (!ext_reset_n)                                                   // RULE7
        begin
            state_r <= PMT_PRIV_THREAD;
            ctrl_r  <= CTRL_RST;
            nest_r  <= '0;
            fault_r <= 1'b0;
            esr_r   <= ESR_RST;
        end
        else
        begin
            state_r <= state_nxt;
            ctrl_r  <= ctrl_nxt;
            nest_r  <= nest_nxt;
            fault_r <= fault_nxt;
            esr_r   <= esr_nxt;
        end
    end

    // Only three encodings exist; user handler never reachable
    assign priv_user       = (state_r == PMT_USER_THREAD);                  // RULE1
    assign handler_mode    = (state_r == PMT_PRIV_HANDLER);                 // RULE4
    assign sel_process_sp  = (state_r == PMT_USER_THREAD)
                           | ((state_r == PMT_PRIV_THREAD)
                              & ctrl_r[CTRL_ALT_BIT]);                      // RULE5 RULE8
    assign ctrl_rdata      = ctrl_r;
    assign exec_status_reg = esr_r;
    assign fault           = fault_r;
endmodule
`default_nettype wire

// >>> test/pmt_checker.sv
// Assertion checker for the privilege mode tracker
`timescale 1ns/100ps
`default_nettype none
module pmt_checker
    import pmt_pkg::*;
(
    // Watched ports
    input wire logic clk_sys, ext_reset_n, esr_we, priv_user, handler_mode, sel_process_sp, fault,
    input wire logic [ESR_W-1:0] esr_wdata,
    input wire pmt_access_t access,
    input wire pmt_exc_t exc
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!ext_reset_n);
    sequence s_flt;
        fault && handler_mode && !priv_user;
    endsequence
    a_no_user_hnd: assert property (!(priv_user && handler_mode)) else $error("bad");
    a_entry_hnd: assert property (exc.entry |=> handler_mode) else $error("bad");
    a_user_flt: assert property (priv_user && |access[4:1] |=> s_flt)
        else $error("bad");
    a_priv_quiet: assert property (!(priv_user || access[0] || esr_we) |=> !fault)
        else $error("bad");
    a_legacy_flt: assert property (access.legacy_isa |=> s_flt) else $error("bad");
    a_user_psp: assert property (priv_user |-> sel_process_sp) else $error("bad");
    a_hnd_msp: assert property (handler_mode |-> !sel_process_sp) else $error("bad");
    a_esr_clr: assert property (esr_we && !esr_wdata[ESR_CMP_BIT] |=> s_flt)
        else $error("bad");
endmodule
bind pmt_tracker pmt_checker chk (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Testbench for the privilege mode tracker
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pmt_pkg::*;
    logic clk_sys = '0, ext_reset_n = '0, ctrl_we = '0, esr_we = '0, r;
    logic priv_user, handler_mode, sel_process_sp, fault;
    logic [1:0] ctrl_wdata = '0, ctrl_rdata;
    logic [31:0] esr_wdata = '0, exec_status_reg;
    pmt_access_t access = '0;
    pmt_exc_t exc = '0;
    int error_cnt = 0, checked = 0, seed = 99, i;
    wire logic [4:0] obs = {exec_status_reg[24], fault, handler_mode, priv_user, sel_process_sp};
    pmt_tracker uut (.*);
    function automatic logic [4:0] st(logic [2:0] fhu, logic a);
        return {1'b1, fhu, !fhu[1] && (fhu[0] || a)};
    endfunction
    task automatic go(string n, logic [10:0] v, logic [4:0] x);
        @(negedge clk_sys);
        {access, exc, ctrl_we, ctrl_wdata, esr_we} = v;
        @(negedge clk_sys);
        {access, exc, ctrl_we, esr_we} = '0;
        checked++;
        if (obs !== x) $display("wrong value %s exp %h got %h", n, x, obs);
        error_cnt += int'(obs !== x);
    endtask
    task automatic cmp_word(string n, logic [31:0] v, logic [31:0] x);
        checked++;
        if (v !== x) $display("wrong value %s exp %h got %h", n, x, v);
        error_cnt += int'(v !== x);
    endtask
    task automatic finish_test(int late);
        error_cnt += late;
        $display("errors %0d of %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    initial #20000 finish_test(1);
    initial
    begin
        repeat (10) @(negedge clk_sys);
        go("rst", 11'h000, 5'h10);
        ext_reset_n = 1'b1;
        esr_wdata = $random(seed) | 32'h0100_0000;
        for (i = 0; i < 4; i++)
        begin
            r = 1'($random(seed));
            go("alt", {8'h01, r, 2'h1}, st(3'h0, r));
            cmp_word("ctrl", 32'(ctrl_rdata), {30'h0, r, 1'b0});
        end
        cmp_word("esr", exec_status_reg, esr_wdata);
        go("usr", 11'h00a, st(3'h1, 1'b1));
        for (i = 0; i < 5; i++)
        begin
            go("flt", 11'h040 << i, st(3'h6, 1'b0));
            go("ret", 11'h010, st(3'h1, 1'b1));
        end
        go("refuse", 11'h008, st(3'h6, 1'b0));
        go("hnd", 11'h00c, st(3'h2, 1'b0));
        cmp_word("ctrl", 32'(ctrl_rdata), 32'h0000_0000);
        go("thr", 11'h010, st(3'h0, 1'b0));
        go("entry", 11'h020, st(3'h2, 1'b0));
        esr_wdata = '0;
        go("clr", 11'h001, st(3'h6, 1'b0));
        cmp_word("esr", exec_status_reg, 32'h0100_0000);
        ext_reset_n = 1'b0;
        go("rst2", 11'h000, 5'h10);
        cmp_word("ctrl", 32'(ctrl_rdata), 32'h0000_0000);
        ext_reset_n = 1'b1;
        go("idle", 11'h000, 5'h10);
        finish_test(0);
    end
endmodule
`default_nettype wire
